//--- logic/baud_pkg.sv
// Constants and decode helpers for the baud rate generator
package baud_pkg;
	localparam int ADDR_W_DEF = 5;
	localparam int DIV_W_DEF = 16;
	// Register byte offsets
	localparam logic [4:0] OFS_BAUD_CONTROL = 5'h00;
	localparam logic [4:0] OFS_RX_STATUS = 5'h04;
	localparam logic [4:0] OFS_DIV_LOW = 5'h08;
	localparam logic [4:0] OFS_DIV_HIGH = 5'h0C;
	localparam logic [4:0] OFS_TX_STATUS = 5'h10;
	localparam logic [4:0] OFS_RATE_COUNT = 5'h14;
	// Field positions
	localparam int BIT_WIDE = 3;
	localparam int BIT_RX_IDLE = 6;
	localparam int BIT_PORT_EN = 7;
	localparam int BIT_SYNC = 4;
	localparam int BIT_HIGH_SPEED = 2;
	localparam int BIT_TX_EMPTY = 1;
	// Writable bits and reset values
	localparam logic [7:0] MASK_BAUD_CONTROL = 8'h1B;
	localparam logic [7:0] MASK_RX_STATUS = 8'hF8;
	localparam logic [7:0] MASK_TX_STATUS = 8'hFD;
	localparam logic [7:0] RST_BAUD_CONTROL = 8'h00;
	localparam logic [7:0] RST_RX_STATUS = 8'h00;
	localparam logic [7:0] RST_TX_STATUS = 8'h00;
	localparam logic [7:0] RST_DIVISOR = 8'h00;
	// Prescale terminal counts: multiplier minus one
	localparam logic [5:0] PRE_TOP_64 = 6'h3F;
	localparam logic [5:0] PRE_TOP_16 = 6'h0F;
	localparam logic [5:0] PRE_TOP_4 = 6'h03;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Multiplier from mode bits
	function automatic logic [5:0] pre_top_sel(input logic sync,
			input logic wide, input logic hs);
		logic [5:0] top;
		top = PRE_TOP_4;
		if (sync) begin
			top = PRE_TOP_4;
		end else if (!wide && !hs) begin
			top = PRE_TOP_64;
		end else if (wide != hs) begin
			top = PRE_TOP_16;
		end else begin
			top = PRE_TOP_4;
		end
		return top;
	endfunction : pre_top_sel
endpackage : baud_pkg

//--- logic/rate_timer.sv
// Free-running prescaler and divisor counter of the rate generator
`timescale 1ns/1ps
module rate_timer #(
	parameter int DIV_W = baud_pkg::DIV_W_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic clear,
	input wire logic wide,
	input wire logic [5:0] pre_top,
	input wire logic [DIV_W-1:0] divisor,
	output logic tick,
	output logic [DIV_W-1:0] count
);
	import baud_pkg::*;

	// Only the 16-bit divisor path is built; refuse anything else early
	if (DIV_W != 16) begin : g_bad_width
		$error("rate_timer serves a 16-bit divisor only");
	end

	logic [5:0] pre_q, pre_d;
	logic [DIV_W-1:0] cnt_q, cnt_d;
	logic tick_q, tick_d;
	logic [DIV_W-1:0] n_eff;

	// Narrow width uses the low byte only
	assign n_eff = wide ? divisor : {8'h00, divisor[7:0]};

	// Count pre_top+1 clocks per step, n+1 steps per bit
	always_comb begin
		pre_d = pre_q;
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (clear || !run) begin
			pre_d = 6'h00;
			cnt_d = '0;
		end else if (pre_q >= pre_top) begin
			pre_d = 6'h00;
			if (cnt_q >= n_eff) begin
				cnt_d = '0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end else begin
			pre_d = pre_q + 6'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pre_q <= 6'h00;
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
	assign count = cnt_q;
endmodule : rate_timer

//--- logic/baud_rate_generator.sv
// AXI4-Lite register file and top of the baud rate generator
`timescale 1ns/1ps
module baud_rate_generator #(
	parameter int ADDR_W = baud_pkg::ADDR_W_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic rx_idle,
	input wire logic tx_shift_empty,
	output logic rate_tick,
	output logic [15:0] rate_count
);
	import baud_pkg::*;

	// Offsets need five address bits; refuse a narrower bus early
	if (ADDR_W < 5) begin : g_bad_addr
		$error("address width must be at least 5");
	end

	// Word offset check shared by read and write decode
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic [4:0] o;
		o = a[4:0];
		// Shift keeps the test legal when no upper address bits exist
		return ((a >> 5) == '0) && (o <= OFS_RATE_COUNT) &&
			(o[1:0] == 2'h0);
	endfunction : mapped

	logic aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [7:0] wbyte_q, wbyte_d;
	logic wlane_q, wlane_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic [7:0] baud_ctl_q, baud_ctl_d, rx_st_q, rx_st_d;
	logic [7:0] tx_st_q, tx_st_d, div_lo_q, div_lo_d, div_hi_q, div_hi_d;
	logic aw_hs, w_hs, wr_go, div_wr;
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0] wr_byte;
	logic wr_lane;
	logic sync, wide, hs, port_en;
	logic [5:0] pre_top;

	// Write channels taken in either order; one write in flight
	assign awready = !aw_got_q && !bvalid_q;
	assign wready = !w_got_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign aw_hs = awvalid && awready;
	assign w_hs = wvalid && wready;
	assign wr_go = (aw_got_q || aw_hs) && (w_got_q || w_hs);
	assign wr_addr = aw_got_q ? awaddr_q : awaddr;
	assign wr_byte = w_got_q ? wbyte_q : wdata[7:0];
	assign wr_lane = w_got_q ? wlane_q : wstrb[0];
	assign div_wr = wr_go && wr_lane && ((wr_addr[4:0] == OFS_DIV_LOW) ||
		(wr_addr[4:0] == OFS_DIV_HIGH)) && mapped(wr_addr);

	// Write handshake and register updates
	always_comb begin
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		awaddr_d = awaddr_q;
		wbyte_d = wbyte_q;
		wlane_d = wlane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		baud_ctl_d = baud_ctl_q;
		rx_st_d = rx_st_q;
		tx_st_d = tx_st_q;
		div_lo_d = div_lo_q;
		div_hi_d = div_hi_q;
		if (aw_hs) begin
			aw_got_d = 1'b1;
			awaddr_d = awaddr;
		end
		if (w_hs) begin
			w_got_d = 1'b1;
			wbyte_d = wdata[7:0];
			wlane_d = wstrb[0];
		end
		if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		if (wr_go) begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
			if (wr_lane && mapped(wr_addr)) begin
				unique case (wr_addr[4:0])
					OFS_BAUD_CONTROL: baud_ctl_d = wr_byte & MASK_BAUD_CONTROL;
					OFS_RX_STATUS: rx_st_d = wr_byte & MASK_RX_STATUS;
					OFS_DIV_LOW: div_lo_d = wr_byte;
					OFS_DIV_HIGH: div_hi_d = wr_byte;
					OFS_TX_STATUS: tx_st_d = wr_byte & MASK_TX_STATUS;
					default: ; // Count register is read-only
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			baud_ctl_q <= RST_BAUD_CONTROL;
			rx_st_q <= RST_RX_STATUS;
			tx_st_q <= RST_TX_STATUS;
			div_lo_q <= RST_DIVISOR;
			div_hi_q <= RST_DIVISOR;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wbyte_q <= wbyte_d;
			wlane_q <= wlane_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			baud_ctl_q <= baud_ctl_d;
			rx_st_q <= rx_st_d;
			tx_st_q <= tx_st_d;
			div_lo_q <= div_lo_d;
			div_hi_q <= div_hi_d;
		end
	end

	// Read path; live status bits are sampled at the handshake
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rdata_d = 32'h0000_0000;
			rresp_d = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			if (mapped(araddr)) begin
				unique case (araddr[4:0])
					OFS_BAUD_CONTROL: begin
						rdata_d[7:0] = baud_ctl_q;
						rdata_d[BIT_RX_IDLE] = rx_idle;
					end
					OFS_RX_STATUS: rdata_d[7:0] = rx_st_q;
					OFS_DIV_LOW: rdata_d[7:0] = div_lo_q;
					OFS_DIV_HIGH: rdata_d[7:0] = div_hi_q;
					OFS_TX_STATUS: begin
						rdata_d[7:0] = tx_st_q;
						rdata_d[BIT_TX_EMPTY] = tx_shift_empty;
					end
					default: rdata_d[15:0] = rate_count;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Mode bits steer the multiplier; port disable clears and stops the timer
	assign sync = tx_st_q[BIT_SYNC];
	assign hs = tx_st_q[BIT_HIGH_SPEED];
	assign wide = baud_ctl_q[BIT_WIDE];
	assign port_en = rx_st_q[BIT_PORT_EN];
	assign pre_top = pre_top_sel(sync, wide, hs);

	rate_timer #(
		.DIV_W(DIV_W_DEF)
	) u_timer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.run(port_en),
		.clear(div_wr),
		.wide(wide),
		.pre_top(pre_top),
		.divisor({div_hi_q, div_lo_q}),
		.tick(rate_tick),
		.count(rate_count)
	);

	AST_RESET_NARROW: assert property (@(posedge sys_clk)
		!rst_n |=> !wide && pre_top == PRE_TOP_64)
		else $error("width not narrow after reset");
	AST_DIV_CLEAR: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		div_wr |=> rate_count == 16'h0000 && !rate_tick)
		else $error("divisor write did not clear timer");
	AST_SYNC_IGNORES_HS: assert property (@(posedge sys_clk)
		disable iff (!rst_n) sync |-> pre_top == PRE_TOP_4)
		else $error("sync rate depends on high speed bit");
	AST_MULT_64: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		!sync && !wide && !hs |-> pre_top == PRE_TOP_64)
		else $error("narrow low speed multiplier wrong");
	AST_MULT_16: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		!sync && wide && !hs |-> pre_top == PRE_TOP_16)
		else $error("wide low speed multiplier wrong");
	AST_HIGH_SPEED: assert property (@(posedge sys_clk)
		disable iff (!rst_n) !sync && hs |->
		pre_top == (wide ? PRE_TOP_4 : PRE_TOP_16))
		else $error("high speed multiplier wrong");
	AST_SYNC_PERIOD: assert property (@(posedge sys_clk)
		disable iff (!rst_n || wr_go)
		rate_tick && sync && {div_hi_q, div_lo_q} == 16'h0000 |=>
		!rate_tick [*3] ##1 rate_tick)
		else $error("sync period with zero divisor not four clocks");
	AST_NARROW_RANGE: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		!wide && !$past(wide) |-> rate_count[15:8] == 8'h00)
		else $error("narrow timer exceeded eight bits");
endmodule : baud_rate_generator

//--- tb/rate_sampler.sv
// Far-side transceiver model: measures the generated bit period
`timescale 1ns/1ps
module rate_sampler (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic rate_tick,
	output int period
);
	int cnt;
	// Clocks from one tick to the next; a reset forgets the last one
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt <= 0;
			period <= 0;
		end else if (rate_tick) begin
			period <= cnt + 1;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : rate_sampler

//--- tb/baud_rate_generator_tb.sv
// Self-checking bench for the baud rate generator
`timescale 1ns/1ps
module baud_rate_generator_tb;
	import baud_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic rx_idle = 1'b1, tx_shift_empty = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, rate_tick;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] rate_count;
	int period, err_count = 0, n_compared = 0;

	always #2 sys_clk = ~sys_clk;

	baud_rate_generator uut (.sys_clk, .rst_n, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.rx_idle, .tx_shift_empty, .rate_tick, .rate_count);

	rate_sampler far_end (.sys_clk, .rst_n, .rate_tick, .period);

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask : check

	// Write one byte; address and data offered together, released apart
	task automatic wr(input logic [4:0] a, input logic [7:0] d,
			output logic [1:0] r);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge sys_clk);
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge sys_clk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		// Spare edge so the next call never re-drives in the same step
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] d,
			output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge sys_clk);
	endtask : rd

	task automatic wait_tick;
		do @(posedge sys_clk); while (!rate_tick);
	endtask : wait_tick

	// Reset values, read-back, status inputs and two unmapped places
	task automatic reg_test;
		logic [31:0] d;
		logic [1:0] r;
		rd(OFS_BAUD_CONTROL, d, r);
		check(d, 32'h40);
		rd(OFS_RX_STATUS, d, r);
		check(d, 32'h0);
		rd(OFS_TX_STATUS, d, r);
		check(d, 32'h2);
		// Live status bits must follow their pins both ways
		rx_idle <= 1'b0;
		tx_shift_empty <= 1'b0;
		rd(OFS_BAUD_CONTROL, d, r);
		check(d, 32'h0);
		rd(OFS_TX_STATUS, d, r);
		check(d, 32'h0);
		rx_idle <= 1'b1;
		tx_shift_empty <= 1'b1;
		wr(OFS_DIV_HIGH, 8'hA5, r);
		rd(OFS_DIV_HIGH, d, r);
		check(d, 32'hA5);
		rd(5'h18, d, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(5'h1C, 8'h55, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
	endtask : reg_test

	// Every mode: measured bit period against multiplier times (n+1)
	task automatic mode_test;
		// Last entry is sync with a zero divisor, the shortest period
		logic [18:0] cfg [7] = '{19'h00101, 19'h10101, 19'h20002,
			19'h30100, 19'h50003, 19'h60005, 19'h40000};
		logic [1:0] r;
		logic s, w, h;
		int m, n;
		wr(OFS_RX_STATUS, 8'h80, r);
		foreach (cfg[i]) begin
			{s, w, h} = cfg[i][18:16];
			wr(OFS_TX_STATUS, {3'h0, s, 1'b0, h, 2'h0}, r);
			wr(OFS_BAUD_CONTROL, {4'h0, w, 3'h0}, r);
			wr(OFS_DIV_HIGH, cfg[i][15:8], r);
			wr(OFS_DIV_LOW, cfg[i][7:0], r);
			m = s ? 4 : (!w && !h) ? 64 : (w != h) ? 16 : 4;
			n = w ? int'(cfg[i][15:0]) : int'(cfg[i][7:0]);
			repeat (3) wait_tick();
			@(posedge sys_clk);
			check(period, m*(n+1));
		end
	endtask : mode_test

	// A divisor write mid-count must not wait for the old long period
	task automatic clear_test;
		logic [1:0] r;
		int c;
		wr(OFS_TX_STATUS, 8'h00, r);
		wr(OFS_BAUD_CONTROL, 8'h00, r);
		wr(OFS_DIV_LOW, 8'hC8, r);
		repeat (200) @(posedge sys_clk);
		// Three 64-clock steps have passed since the clearing write
		check({16'h0000, rate_count}, 32'h3);
		wr(OFS_DIV_LOW, 8'h00, r);
		c = 0;
		do begin
			@(posedge sys_clk);
			c++;
		end while (!rate_tick);
		check({31'h0, (c > 56 && c < 68)}, 32'h1);
	endtask : clear_test

	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		reg_test();
		mode_test();
		clear_test();
		stop_test();
	end

	// Watchdog well beyond the expected run of about 4400 clocks
	initial begin
		#200000;
		err_count++;
		stop_test();
	end
endmodule : baud_rate_generator_tb
